// ===== psi_core.sv
// program counter, return stack and indirect access logic behind an apb slave
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "psi_map.svh"
module psi_core #(
    parameter logic [12:0] INT_VECTOR = `PSI_INT_VECTOR,
    parameter int STACK_DEPTH = `PSI_STACK_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic op_valid,
    input wire psi_pkg::psi_op_t op_code,
    input wire logic [10:0] op_target,
    input wire logic [7:0] op_offset,
    output logic [12:0] pc,
    output logic [8:0] rf_addr,
    output logic [7:0] rf_wdata,
    output logic rf_we,
    output logic rf_re,
    input wire logic [7:0] rf_rdata
);
    import psi_pkg::*;

    psi_state_t st_q;
    psi_state_t st_d;
    logic stk_push;
    logic stk_pop;
    logic [12:0] stk_push_data;
    logic [12:0] stk_top;
    logic setup;
    logic done;
    logic hit;
    logic is_win;
    logic [31:0] rd_mux;
    logic [7:0] low_sum;

    // return stack lives outside both address spaces
    psi_stack #(
        .DEPTH(STACK_DEPTH),
        .WIDTH(13)
    ) u_stack (
        .pclk(pclk),
        .presetn(presetn),
        .push(stk_push),
        .pop(stk_pop),
        .push_data(stk_push_data),
        .top_data(stk_top)
    );

    // apb phase decode
    assign setup = psel && !penable;
    assign done = psel && penable && st_q.pready;
    assign is_win = (paddr == `PSI_OFF_WINDOW);
    assign hit = (paddr == `PSI_OFF_PC_LOW) || (paddr == `PSI_OFF_LATCH)
        || (paddr == `PSI_OFF_POINTER) || is_win || (paddr == `PSI_OFF_CTRL);

    // computed jump sum kept to eight bits so no carry reaches the top
    assign low_sum = st_q.pc[7:0] + op_offset;

    // stack requests from the decoder
    always_comb begin
        stk_push = 1'b0;
        stk_pop = 1'b0;
        stk_push_data = st_q.pc;
        if (op_valid) begin
            unique case (op_code)
                PSI_OP_CALL: begin
                    stk_push = 1'b1;
                    stk_push_data = st_q.pc + 13'h0001;
                end
                PSI_OP_INT: begin
                    stk_push = 1'b1;
                    stk_push_data = st_q.pc;
                end
                PSI_OP_RET: begin
                    stk_pop = 1'b1;
                end
                PSI_OP_NONE, PSI_OP_STEP, PSI_OP_JUMP, PSI_OP_ADD_LOW: begin
                    stk_push = 1'b0;
                end
                default: begin
                    stk_push = 1'b0;
                end
            endcase
        end
    end

    // read mux; upper pc bits have no read path at all
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == `PSI_OFF_PC_LOW) begin
            rd_mux[7:0] = st_q.pc[7:0];
        end else if (paddr == `PSI_OFF_LATCH) begin
            rd_mux[7:0] = st_q.latch;
        end else if (paddr == `PSI_OFF_POINTER) begin
            rd_mux[7:0] = st_q.pointer;
        end else if (paddr == `PSI_OFF_CTRL) begin
            rd_mux[`PSI_CTRL_BANK_BIT] = st_q.bank;
        end
    end

    // next state: decoder first, software writes override the pc after
    always_comb begin
        st_d = st_q;
        st_d.rf_we = 1'b0;
        st_d.rf_re = 1'b0;

        // sequencing; latch is never touched here
        if (op_valid) begin
            unique case (op_code)
                PSI_OP_STEP: begin
                    st_d.pc = st_q.pc + 13'h0001;
                end
                PSI_OP_CALL, PSI_OP_JUMP: begin
                    st_d.pc = {st_q.latch[4:3], op_target};
                end
                PSI_OP_RET: begin
                    st_d.pc = stk_top;
                end
                PSI_OP_INT: begin
                    st_d.pc = INT_VECTOR;
                end
                PSI_OP_ADD_LOW: begin
                    st_d.pc = {st_q.latch[4:0], low_sum};
                end
                PSI_OP_NONE: begin
                    st_d.pc = st_q.pc;
                end
                default: begin
                    st_d.pc = st_q.pc;
                end
            endcase
        end

        // transfer completes this edge; drop ready and apply writes
        if (done) begin
            st_d.pready = 1'b0;
            st_d.pslverr = 1'b0;
            if (pwrite) begin
                if (paddr == `PSI_OFF_PC_LOW) begin
                    st_d.pc = {st_q.latch[4:0], pwdata[7:0]};
                end else if (paddr == `PSI_OFF_LATCH) begin
                    st_d.latch = pwdata[7:0];
                end else if (paddr == `PSI_OFF_POINTER) begin
                    st_d.pointer = pwdata[7:0];
                end else if (paddr == `PSI_OFF_CTRL) begin
                    st_d.bank = pwdata[`PSI_CTRL_BANK_BIT];
                end else if (is_win && st_q.pointer != 8'h00) begin
                    st_d.rf_we = 1'b1;
                    st_d.rf_addr = {1'b0, st_q.pointer};
                    st_d.rf_wdata = pwdata[7:0];
                end
            end
        end

        // setup phase; window reads wait one cycle for the register file
        if (setup) begin
            if (is_win && !pwrite) begin
                st_d.win_rd = 1'b1;
                if (st_q.pointer != 8'h00) begin
                    st_d.rf_re = 1'b1;
                    st_d.rf_addr = {1'b0, st_q.pointer};
                end
            end else begin
                st_d.pready = 1'b1;
                st_d.pslverr = !hit;
                st_d.prdata = pwrite ? 32'h0000_0000 : rd_mux;
            end
        end

        // window read data arrives while rf_re is high
        if (st_q.win_rd) begin
            st_d.win_rd = 1'b0;
            st_d.pready = 1'b1;
            st_d.pslverr = 1'b0;
            if (st_q.rf_re) begin
                st_d.prdata = {24'h00_0000, rf_rdata};
            end else begin
                st_d.prdata = {24'h00_0000, `PSI_SELF_READ};
            end
        end
    end

    // one register for all state; any reset clears the pc
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
            st_q.pc <= `PSI_PC_RESET;
            st_q.latch <= `PSI_LATCH_RESET;
            st_q.pointer <= `PSI_POINTER_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // every output straight from the state register
    assign pc = st_q.pc;
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign rf_addr = st_q.rf_addr;
    assign rf_wdata = st_q.rf_wdata;
    assign rf_we = st_q.rf_we;
    assign rf_re = st_q.rf_re;
endmodule
`default_nettype wire

// ===== psi_map.svh
// register offsets, field positions and reset values of the sequencing block
`ifndef PSI_MAP_SVH
`define PSI_MAP_SVH
`define PSI_OFF_PC_LOW 8'h00
`define PSI_OFF_LATCH 8'h04
`define PSI_OFF_POINTER 8'h08
`define PSI_OFF_WINDOW 8'h0c
`define PSI_OFF_CTRL 8'h10
`define PSI_CTRL_BANK_BIT 0
`define PSI_PC_RESET 13'h0000
`define PSI_LATCH_RESET 8'h00
`define PSI_POINTER_RESET 8'h00
`define PSI_INT_VECTOR 13'h0004
`define PSI_SELF_READ 8'h00
`define PSI_STACK_DEPTH 8
`endif

// ===== psi_pkg.sv
// types shared by the sequencing block, its assertions and its bench
`default_nettype none
package psi_pkg;
    typedef enum logic [2:0] {
        PSI_OP_NONE = 3'b000,
        PSI_OP_STEP = 3'b001,
        PSI_OP_CALL = 3'b010,
        PSI_OP_JUMP = 3'b011,
        PSI_OP_RET = 3'b100,
        PSI_OP_INT = 3'b101,
        PSI_OP_ADD_LOW = 3'b110
    } psi_op_t;

    typedef struct packed {
        logic [12:0] pc;
        logic [7:0] latch;
        logic [7:0] pointer;
        logic bank;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic win_rd;
        logic [8:0] rf_addr;
        logic [7:0] rf_wdata;
        logic rf_we;
        logic rf_re;
    } psi_state_t;
endpackage
`default_nettype wire

// ===== psi_stack.sv
// circular return-address stack, depth and width set by parameters
`timescale 1ns/1ps
`default_nettype none
module psi_stack #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 13
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic push,
    input wire logic pop,
    input wire logic [WIDTH-1:0] push_data,
    output logic [WIDTH-1:0] top_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] ptr;
    } psi_stack_state_t;

    psi_stack_state_t stk_q;
    psi_stack_state_t stk_d;

    // newest entry sits just below the pointer; wraps with no overflow flag
    assign top_data = stk_q.mem[stk_q.ptr - PW'(1)];

    // pointer only moves in hardware, software has no path to it
    always_comb begin
        stk_d = stk_q;
        if (push) begin
            stk_d.mem[stk_q.ptr] = push_data;
            stk_d.ptr = stk_q.ptr + PW'(1);
        end else if (pop) begin
            stk_d.ptr = stk_q.ptr - PW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stk_q <= '0;
        end else begin
            stk_q <= stk_d;
        end
    end
endmodule
`default_nettype wire

// ===== psi_core_properties.sv
// port-level assertions for the sequencing block
`timescale 1ns/1ps
`default_nettype none
module psi_core_properties #(
    parameter logic [12:0] INT_VECTOR = 13'h0004
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic op_valid,
    input wire psi_pkg::psi_op_t op_code,
    input wire logic [10:0] op_target,
    input wire logic [7:0] op_offset,
    input wire logic [12:0] pc,
    input wire logic [8:0] rf_addr,
    input wire logic rf_we,
    input wire logic rf_re
);
    import psi_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a completing low-byte write beats any op in the same cycle
    wire logic pcw = psel && penable && pready && pwrite && paddr == 8'h00;
    wire logic go = op_valid && !pcw;
    chk_step_inc: assert property (go && op_code == PSI_OP_STEP |=> pc == $past(pc) + 13'h1)
        else $error("step did not add one");
    chk_jump_page: assert property (go && op_code inside {PSI_OP_JUMP, PSI_OP_CALL}
        |=> pc[10:0] == $past(op_target)) else $error("branch target lost");
    chk_call_ret: assert property (go && op_code == PSI_OP_CALL ##1 go && op_code == PSI_OP_RET
        |=> pc == $past(pc, 2) + 13'h1) else $error("return address wrong");
    chk_add_low: assert property (go && op_code == PSI_OP_ADD_LOW
        |=> pc[7:0] == 8'($past(pc[7:0]) + $past(op_offset))) else $error("computed jump low byte");
    chk_int_vec: assert property (go && op_code == PSI_OP_INT |=> pc == INT_VECTOR)
        else $error("interrupt vector wrong");
    chk_pc_hold: assert property ((!op_valid || op_code == PSI_OP_NONE) && !pcw |=> $stable(pc))
        else $error("pc moved without cause");
    chk_ready_one: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_rf_addr: assert property (rf_re || rf_we |-> rf_addr[8] == 1'b0 && rf_addr[7:0] != 8'h00)
        else $error("bad register file access");
    chk_win_wait: assert property (psel && !penable && !pwrite && paddr == 8'h0c
        |=> !pready ##1 pready) else $error("window read wait wrong");
endmodule
bind psi_core psi_core_properties #(.INT_VECTOR(INT_VECTOR)) u_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pready, .pslverr, .op_valid, .op_code, .op_target, .op_offset,
    .pc, .rf_addr, .rf_we, .rf_re);
`default_nettype wire

// ===== psi_rf_model.sv
// register file behind the indirect window
`timescale 1ns/1ps
`default_nettype none
module psi_rf_model (
    input wire logic pclk,
    input wire logic [8:0] rf_addr,
    input wire logic [7:0] rf_wdata,
    input wire logic rf_we,
    input wire logic rf_re,
    output logic [7:0] rf_rdata
);
    logic [7:0] mem [256] = '{default: 8'h00};
    // plain storage, written on the strobe
    always @(posedge pclk) begin
        if (rf_we) mem[rf_addr[7:0]] <= rf_wdata;
    end
    // outside a read the data toggles so stale sampling shows
    assign rf_rdata = rf_re ? mem[rf_addr[7:0]] : {8{pclk}} ^ 8'ha5;
endmodule
`default_nettype wire

// ===== pc_stack_indirect_addr_bench.sv
// self-checking bench for the sequencing block
`timescale 1ns/1ps
`default_nettype none
`include "psi_map.svh"
module pc_stack_indirect_addr_bench;
    import psi_pkg::*;
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, op_valid = '0, on = '0;
    logic [7:0] paddr = '0, op_offset = '0, l = '0, rf_wdata, rf_rdata;
    logic [31:0] pwdata = '0, rd, prdata, r = 32'h7e54;
    logic [10:0] op_target = '0;
    psi_op_t op_code = PSI_OP_NONE;
    logic [12:0] pc, e = '0, stk [8];
    logic [2:0] sp = '0;
    logic [8:0] rf_addr;
    logic pready, pslverr, er, rf_we, rf_re;
    int errors = 0, compares = 0;
    always #50 pclk = ~pclk;
    psi_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .op_valid, .op_code, .op_target, .op_offset, .pc, .rf_addr,
        .rf_wdata, .rf_we, .rf_re, .rf_rdata);
    psi_rf_model u_rf (.pclk, .rf_addr, .rf_wdata, .rf_we, .rf_re, .rf_rdata);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected pc and stack; pointer wraps like the real stack
    function automatic void model(input psi_op_t c, input logic [10:0] t, input logic [7:0] o);
        case (c)
            PSI_OP_STEP: e = e + 13'h1;
            PSI_OP_CALL, PSI_OP_INT: begin
                stk[sp] = (c == PSI_OP_CALL) ? e + 13'h1 : e;
                sp = sp + 3'h1;
                e = (c == PSI_OP_CALL) ? {l[4:3], t} : `PSI_INT_VECTOR;
            end
            PSI_OP_JUMP: e = {l[4:3], t};
            PSI_OP_RET: begin
                sp = sp - 3'h1;
                e = stk[sp];
            end
            PSI_OP_ADD_LOW: e = {l[4:0], 8'(e[7:0] + o)};
            default: ;
        endcase
    endfunction
    // leaves op_valid high so ops can run back to back
    task automatic op(input psi_op_t c, input logic [10:0] t, input logic [7:0] o);
        op_valid <= 1'h1;
        op_code <= c;
        op_target <= t;
        op_offset <= o;
        @(posedge pclk);
        model(c, t, o);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        op_valid <= 1'h0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            errors++;
            $display("mismatch at %0t: no pready", $time);
            end_of_test();
        end
        if (w && a == 8'h04) l = d[7:0];
        if (w && a == 8'h00) e = {l[4:0], d[7:0]};
        @(posedge pclk);
    endtask
    // pc compared mid-cycle, once its edge has settled
    always @(negedge pclk) if (on) check(32'(pc), 32'(e));
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        on = 1'h1;
        apb(1'h0, 8'h00, 32'h0);
        check(rd, 32'h0);
        apb(1'h1, 8'h04, 32'h1f);
        apb(1'h1, 8'h00, 32'hff);
        op(PSI_OP_STEP, 11'h0, 8'h0);
        op(PSI_OP_JUMP, 11'h7ff, 8'h0);
        op(PSI_OP_ADD_LOW, 11'h0, 8'h02);
        apb(1'h1, 8'h14, 32'h1);
        check(32'(er), 32'h1);
        $display("test paging done");
        for (int i = 0; i < 9; i++) op(PSI_OP_CALL, 11'(i) + 11'h100, 8'h0);
        op(PSI_OP_INT, 11'h0, 8'h0);
        repeat (10) op(PSI_OP_RET, 11'h0, 8'h0);
        op(PSI_OP_CALL, 11'h2aa, 8'h0);
        op(PSI_OP_RET, 11'h0, 8'h0);
        apb(1'h0, 8'h04, 32'h0);
        check(rd, 32'h1f);
        $display("test stack done");
        apb(1'h1, 8'h10, 32'h1);
        apb(1'h1, 8'h08, 32'h5);
        apb(1'h1, 8'h0c, 32'ha5);
        apb(1'h0, 8'h0c, 32'h0);
        check(rd, 32'ha5);
        apb(1'h1, 8'h08, 32'h0);
        apb(1'h1, 8'h0c, 32'h3c);
        apb(1'h0, 8'h0c, 32'h0);
        check(rd, 32'h0);
        apb(1'h1, 8'h08, 32'h5);
        apb(1'h0, 8'h0c, 32'h0);
        check(rd, 32'ha5);
        $display("test window done");
        repeat (300) begin
            r = lfsr(r);
            if (r[12:10] == 3'h0) apb(1'h1, r[13] ? 8'h04 : 8'h00, {24'h0, r[31:24]});
            else op(psi_op_t'(r[2:0] == 3'h7 ? 3'h1 : r[2:0]), r[23:13], r[31:24]);
        end
        apb(1'h0, 8'h00, 32'h0);
        check(rd, 32'(e[7:0]));
        $display("test random done");
        presetn <= 1'h0;
        e = '0;
        l = '0;
        sp = '0;
        @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, 8'h04, 32'h0);
        check(rd, 32'h0);
        apb(1'h0, 8'h00, 32'h0);
        check(rd, 32'h0);
        $display("test reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
